/* logic/fpd_map.svh */
/*
  constants of the front panel display and key controller: timing figures
  and derived cycle counts. assumes a 25 MHz system clock.
*/
`ifndef FPD_MAP_SVH
`define FPD_MAP_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define FPD_CLOCK_HZ        25000000
`define FPD_SHOW_TIME_MS    1000
`define FPD_LIGHT_TIME_MS   60000
`define FPD_DEBOUNCE_US     10000
`define FPD_SHOW_CYCLES     ((`FPD_CLOCK_HZ / 1000) * `FPD_SHOW_TIME_MS)
`define FPD_LIGHT_CYCLES    ((`FPD_CLOCK_HZ / 1000) * `FPD_LIGHT_TIME_MS)
`define FPD_DEBOUNCE_CYCLES ((`FPD_CLOCK_HZ / 1000000) * `FPD_DEBOUNCE_US)

// ----------------------------------------
// key indices
// ----------------------------------------
`define FPD_KEY_ENTER 0
`define FPD_KEY_UP    1
`define FPD_KEY_DOWN  2
`define FPD_KEY_ESC   3
`define FPD_NUM_KEYS  4

`endif

/* logic/fpd_pkg.sv */
/*
  types of the front panel display and key controller.
  assumes nothing of its surroundings.
*/
package fpd_pkg;

  // ----------------------------------------
  // display modes
  // ----------------------------------------
  typedef enum logic [0:0] {
    FPD_CYCLING,
    FPD_HELD
  } fpd_mode_t;

endpackage

/* logic/fpd_panel.sv */
/*
  front panel controller: picks the status parameter shown on the display,
  steps through the list automatically or under key control, and drives
  the backlight with an inactivity timeout.
  assumes keys are active high (they may be asynchronous to CLOCK), and that the
  display driver shows the parameter whose index is on PARAM_SEL.
*/
// Notes on behaviour
// [R1] display shows unit statuses, buses and I/O ports, chosen from a parameter list
// [R2] after reset the backlight is on and the mode is automatic cycling
// [R3] cycling shows each parameter about one second, then moves to the next, forever
// [R4] in cycling only Enter acts; Up, Down and Escape are ignored
// [R5] Enter in cycling holds the shown parameter and stops advancing
// [R6] held mode: Up selects previous parameter, Down selects next
// [R7] held mode: Escape returns to automatic cycling
// [R8] backlight goes off one minute after the last press; each press restarts it
// [R9] with the backlight off, any key switches it back on
// [R10] keys are synchronised, debounced, and each press acts once on its edge
// [R11] Up and Down wrap around at the ends of the parameter list
`timescale 1ns/100ps
`include "fpd_map.svh"

module fpd_panel #(
  parameter int NUM_PARAMS   = 16,
  parameter int SHOW_CYCLES  = `FPD_SHOW_CYCLES,
  parameter int LIGHT_CYCLES = `FPD_LIGHT_CYCLES,
  parameter int DEB_CYCLES   = `FPD_DEBOUNCE_CYCLES
) (
  input  wire logic                          CLOCK,
  input  wire logic                          RESETN,
  input  wire logic [`FPD_NUM_KEYS-1:0]      KEYS,
  output logic      [$clog2(NUM_PARAMS)-1:0] PARAM_SEL,
  output logic                               HELD,
  output logic                               BACKLIGHT
);

  localparam int PW = $clog2(NUM_PARAMS);
  localparam int NK = `FPD_NUM_KEYS;
  localparam logic [PW-1:0] LAST = PW'(NUM_PARAMS - 1);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [NK-1:0]      sync1;
    logic [NK-1:0]      sync2;
    logic [NK-1:0]      stable;
    logic [NK-1:0][23:0] deb;
    fpd_pkg::fpd_mode_t mode;
    logic [PW-1:0]      sel;
    logic [31:0]        show;
    logic [31:0]        light;
    logic               lit;
  } fpd_state_t;

  fpd_state_t st;
  fpd_state_t next_st;
  logic [NK-1:0] press;

  // ----------------------------------------
  // debounce, one per key
  // ----------------------------------------
  // counter width covers 10 ms at 25 MHz with room to spare
  // a held key gives one pulse: stable only follows sync2 after a full quiet count
  genvar k;
  generate
    for (k = 0; k < NK; k++)
    begin : g_key
      assign press[k] = st.sync2[k] && !st.stable[k]
                        && st.deb[k] == 24'(DEB_CYCLES - 1);  // R10
    end
  endgenerate

  always_comb
  begin
    next_st = st;
    next_st.sync1 = KEYS;         // R10
    next_st.sync2 = st.sync1;     // R10
    for (int i = 0; i < NK; i++)
    begin
      if (st.sync2[i] == st.stable[i])
        next_st.deb[i] = 24'h000000;
      else if (st.deb[i] == 24'(DEB_CYCLES - 1))
      begin
        next_st.deb[i] = 24'h000000;
        next_st.stable[i] = st.sync2[i];  // R10
      end
      else
        next_st.deb[i] = st.deb[i] + 24'h000001;
    end

    // backlight: any press relights and restarts the timeout
    if (|press)
    begin
      next_st.lit = 1'b1;          // R9
      next_st.light = 32'h00000000;  // R8
    end
    else if (st.lit)
    begin
      if (st.light == 32'(LIGHT_CYCLES - 1))
        next_st.lit = 1'b0;        // R8
      else
        next_st.light = st.light + 32'h00000001;
    end

    // parameter selection; the list feeds the display driver
    case (st.mode)
      fpd_pkg::FPD_CYCLING:
      begin
        if (press[`FPD_KEY_ENTER])  // R4
        begin
          next_st.mode = fpd_pkg::FPD_HELD;  // R5
          next_st.show = 32'h00000000;
        end
        else if (st.show == 32'(SHOW_CYCLES - 1))  // R3
        begin
          next_st.show = 32'h00000000;
          next_st.sel = (st.sel == LAST) ? '0 : st.sel + PW'(1);  // R3 R1
        end
        else
          next_st.show = st.show + 32'h00000001;  // R3
      end
      fpd_pkg::FPD_HELD:
      begin
        if (press[`FPD_KEY_ESC])
        begin
          next_st.mode = fpd_pkg::FPD_CYCLING;  // R7
          next_st.show = 32'h00000000;
        end
        else if (press[`FPD_KEY_UP])
          next_st.sel = (st.sel == '0) ? LAST : st.sel - PW'(1);  // R6 R11
        else if (press[`FPD_KEY_DOWN])
          next_st.sel = (st.sel == LAST) ? '0 : st.sel + PW'(1);  // R6 R11
      end
      default:
        next_st.mode = fpd_pkg::FPD_CYCLING;
    endcase
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      st <= '0;
      st.mode <= fpd_pkg::FPD_CYCLING;  // R2
      st.lit <= 1'b1;                   // R2
    end
    else
      st <= next_st;
  end

  assign PARAM_SEL = st.sel;
  assign HELD = (st.mode == fpd_pkg::FPD_HELD);
  assign BACKLIGHT = st.lit;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);

  sequence enter_cyc;
    press[`FPD_KEY_ENTER] && st.mode == fpd_pkg::FPD_CYCLING;
  endsequence

  reset_state_a: assert property ($rose(RESETN) |-> BACKLIGHT && !HELD)  // R2
    else $error("wrong state after reset");
  cycle_step_a: assert property (  // R3
    st.mode == fpd_pkg::FPD_CYCLING && st.show == 32'(SHOW_CYCLES - 1) && !(|press)
    |=> PARAM_SEL == (($past(PARAM_SEL) == LAST) ? '0 : $past(PARAM_SEL) + PW'(1)))
    else $error("cycling did not advance");
  cycle_hold_a: assert property (  // R4
    st.mode == fpd_pkg::FPD_CYCLING && st.show != 32'(SHOW_CYCLES - 1)
    |=> $stable(PARAM_SEL))
    else $error("selection moved early in cycling");
  enter_hold_a: assert property (enter_cyc |=> HELD && $stable(PARAM_SEL))  // R5
    else $error("enter did not hold");
  up_wrap_a: assert property (HELD && press[`FPD_KEY_UP] && !press[`FPD_KEY_ESC]  // R11
    && PARAM_SEL == '0 |=> PARAM_SEL == LAST)
    else $error("up did not wrap");
  down_step_a: assert property (HELD && press[`FPD_KEY_DOWN] && press[3:1] == 3'b010  // R6
    |=> PARAM_SEL == (($past(PARAM_SEL) == LAST) ? '0 : $past(PARAM_SEL) + PW'(1)))
    else $error("down did not step");
  esc_return_a: assert property (HELD && press[`FPD_KEY_ESC] |=> !HELD)  // R7
    else $error("escape did not resume cycling");
  light_off_a: assert property (st.lit && st.light == 32'(LIGHT_CYCLES - 1) && !(|press)  // R8
    |=> !BACKLIGHT)
    else $error("backlight timeout missed");
  light_on_a: assert property (|press |=> BACKLIGHT && st.light == 32'h00000000)  // R9
    else $error("key did not relight");
  press_once_a: assert property (press[0] |=> !press[0])  // R10
    else $error("press acted twice");

  // ----------------------------------------
  // checks: ignored keys and held mode
  // ----------------------------------------
  sequence held_idle;
    HELD && !(|press);
  endsequence

  sequence cyc_other_key;
    !HELD && |press && !press[`FPD_KEY_ENTER];
  endsequence

  ignore_keys_a: assert property (cyc_other_key |=> !HELD)  // R4
    else $error("key other than enter acted in cycling");
  held_keep_a: assert property (held_idle |=> HELD && $stable(PARAM_SEL))  // R5
    else $error("held selection moved");
  up_step_a: assert property (HELD && press[3:1] == 3'b001  // R6
    |=> PARAM_SEL == (($past(PARAM_SEL) == '0) ? LAST : $past(PARAM_SEL) - PW'(1)))
    else $error("up did not step back");
  down_wrap_a: assert property (HELD && press[3:1] == 3'b010  // R11
    && PARAM_SEL == LAST |=> PARAM_SEL == '0)
    else $error("down did not wrap");

  // ----------------------------------------
  // checks: backlight
  // ----------------------------------------
  // a stalled timeout count would leave the light on for ever
  light_keep_a: assert property (st.lit && st.light != 32'(LIGHT_CYCLES - 1)  // R8
    && !(|press) |=> BACKLIGHT && st.light == $past(st.light) + 32'h00000001)
    else $error("backlight dropped early");
  dark_keep_a: assert property (!BACKLIGHT && !(|press) |=> !BACKLIGHT)  // R9
    else $error("backlight came on without a key");

endmodule

/* test/fpd_keypad.sv */
/*
  partner model: the front panel keypad, pressing one key on request.
  assumes the controller samples KEYS on the rising CLOCK edge.
*/
`timescale 1ns/100ps
module fpd_keypad (
  input  wire logic       CLOCK,
  output logic      [3:0] KEYS
);
  initial KEYS = 4'h0;
  // release lasts past the debounce time, so the next press counts
  task automatic press(input int key, input int hold);
    @(posedge CLOCK);
    KEYS[key] <= 1'b1;
    repeat (hold) @(posedge CLOCK);
    KEYS[key] <= 1'b0;
    repeat (10) @(posedge CLOCK);
  endtask
endmodule

/* test/tb_top.sv */
/*
  bench of the front panel controller with shortened counts.
  assumes the keypad model drives KEYS and outputs settle 1 ns past the edge.
*/
`timescale 1ns/100ps
module tb_top;
  localparam int SHOW = 20;
  localparam int LIGHT = 200;
  logic       clock;
  logic       resetn;
  logic [3:0] keys;
  logic [3:0] sel;
  logic       held;
  logic       light;
  logic [3:0] p;
  int         mismatches;
  int         checks_done;
  int         cycles;

  fpd_panel #(.NUM_PARAMS(16), .SHOW_CYCLES(SHOW), .LIGHT_CYCLES(LIGHT), .DEB_CYCLES(3))
  fpd_panel_i (.CLOCK(clock), .RESETN(resetn), .KEYS(keys), .PARAM_SEL(sel),
    .HELD(held), .BACKLIGHT(light));
  fpd_keypad fpd_keypad_i (.CLOCK(clock), .KEYS(keys));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic key(input int k, input int hold);
    fpd_keypad_i.press(k, hold);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard, about two and a half times the expected run
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_cycle();
    p = sel;
    while (sel === p) tick(1);
    p = sel;
    tick(SHOW - 1);
    check(sel, p);
    tick(1);
    check(sel, p + 4'h1);
  endtask
  task automatic t_ignore();
    for (int k = 1; k < 4; k++)
    begin
      key(k, 8);
      check(held, 1'b0);
    end
    check(sel, 4'h4);
  endtask
  task automatic t_hold();
    key(0, 8);
    check(held, 1'b1);
    p = sel;
    tick(2 * SHOW);
    check(sel, p);
    key(0, 8);
    check(held, 1'b1);
  endtask
  task automatic t_step();
    // sixteen steps each way pass both ends of the list
    for (int i = 0; i < 16; i++)
    begin
      key(2, 8);
      p = p + 4'h1;
      check(sel, p);
    end
    for (int i = 0; i < 16; i++)
    begin
      key(1, 8);
      p = p - 4'h1;
      check(sel, p);
    end
    key(2, 40);
    check(sel, p + 4'h1);
    check(light, 1'b1);
  endtask
  task automatic t_esc_light();
    key(3, 8);
    check(held, 1'b0);
    p = sel;
    tick(SHOW + 1);
    check(sel, p + 4'h1);
    tick(LIGHT - 60);
    check(light, 1'b1);
    tick(50);
    check(light, 1'b0);
    key(1, 8);
    check(light, 1'b1);
    check(held, 1'b0);
  endtask
  task automatic t_reset();
    key(0, 8);
    check(held, 1'b1);
    @(posedge clock);
    resetn <= 1'b0;
    tick(6);
    check(sel, 4'h0);
    check(held, 1'b0);
    check(light, 1'b1);
    @(posedge clock);
    resetn <= 1'b1;
    tick(SHOW);
    check(sel, 4'h1);
  endtask

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial
  begin
    resetn = 1'b0;
    tick(5);
    check(sel, 4'h0);
    check(held, 1'b0);
    check(light, 1'b1);
    @(posedge clock);
    resetn <= 1'b1;
    t_cycle();
    t_ignore();
    t_hold();
    t_step();
    t_esc_light();
    t_reset();
    tally_and_finish();
  end
endmodule
